// ==== src/ghc_pkg.sv ====
// shared constants, states and carrier types for the global parameter / homing command decoder
package ghc_pkg;

	// frame layout: byte positions inside a nine-byte command or reply
	localparam logic [3:0] FRAME_LAST = 4'h8;
	localparam logic [3:0] POS_ADDR = 4'h0;
	localparam logic [3:0] POS_INSTR = 4'h1;
	localparam logic [3:0] POS_TYPE = 4'h2;
	localparam logic [3:0] POS_BANK = 4'h3;
	localparam logic [3:0] POS_VAL3 = 4'h4;
	localparam logic [3:0] POS_VAL2 = 4'h5;
	localparam logic [3:0] POS_VAL1 = 4'h6;
	localparam logic [3:0] POS_VAL0 = 4'h7;
	localparam logic [3:0] POS_SUM = 4'h8;

	// instruction codes handled here
	localparam logic [7:0] CMD_GET_AXIS = 8'h06;
	localparam logic [7:0] CMD_SET_GLOBAL = 8'h09;
	localparam logic [7:0] CMD_GET_GLOBAL = 8'h0a;
	localparam logic [7:0] CMD_STORE_GLOBAL = 8'h0b;
	localparam logic [7:0] CMD_RESTORE_GLOBAL = 8'h0c;
	localparam logic [7:0] CMD_HOMING = 8'h0d;

	// banks, selected parameters and homing sub-commands
	localparam logic [7:0] BANK_MODULE = 8'h00;
	localparam logic [7:0] BANK_USER = 8'h02;
	localparam logic [7:0] BANK_IRQ = 8'h03;
	localparam logic [7:0] PARAM_BUS_ADDR = 8'h42;
	localparam logic [7:0] AXIS_ACT_POS = 8'h01;
	localparam logic [7:0] HOME_START = 8'h00;
	localparam logic [7:0] HOME_STOP = 8'h01;
	localparam logic [7:0] HOME_STATUS = 8'h02;
	localparam logic [7:0] MOTOR_LAST = 8'h02;
	localparam int NUM_MOTORS = 3;
	localparam logic [7:0] PARAM_LAST = 8'hff;

	// reply status codes
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_SUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;

	// reset values
	localparam logic [7:0] ADDR_RESET = 8'h01;
	localparam logic [7:0] HOST_ADDR = 8'h02;

	// reply buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// main sequencer states, one-hot
	typedef enum logic [4:0] {
		S_BOOT = 5'b00001,
		S_RECV = 5'b00010,
		S_EXEC = 5'b00100,
		S_NVWAIT = 5'b01000,
		S_REPLY = 5'b10000
	} ghc_state_t;

	// request to the non-volatile store
	typedef struct packed {
		logic req;
		logic we;
		logic [7:0] bank;
		logic [7:0] idx;
		logic [31:0] wdata;
	} ghc_nv_req_t;

	// answer from the non-volatile store
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} ghc_nv_rsp_t;

	// per-motor homing strobes
	typedef struct packed {
		logic [NUM_MOTORS-1:0] start;
		logic [NUM_MOTORS-1:0] stop;
	} ghc_home_t;

endpackage : ghc_pkg

// ==== src/ghc_fifo.sv ====
// shift-register fifo holding reply bytes on their way out
`timescale 1ns/100ps
module ghc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int CW = $clog2(DEPTH) + 1;

	// whole fifo state
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [CW-1:0] count;
		logic valid;
		logic ready;
	} ghc_fifo_st_t;

	ghc_fifo_st_t q, d;
	logic push;
	logic pop;
	logic [CW-1:0] wpos;

	// entries shift toward slot 0 so the head is always a flop
	always_comb
	begin
		d = q;
		push = in_valid & q.ready;
		pop = q.valid & out_ready;
		if (pop)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
				d.data[i] = q.data[i+1];
		end
		// new word lands just above the survivors
		wpos = q.count - {{(CW-1){1'b0}}, pop};
		if (push)
			d.data[wpos[CW-2:0]] = in_data;
		d.count = q.count + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
		// flags follow the next count so they never lag by a cycle
		d.valid = (d.count != '0);
		d.ready = (d.count != CW'(DEPTH));
	end

	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q <= '0;
			q.ready <= 1'b1;
		end
		else
			q <= d;
	end

	assign in_ready = q.ready;
	assign out_valid = q.valid;
	assign out_data = q.data[0];

endmodule : ghc_fifo

// ==== src/ghc_decoder.sv ====
// command decoder for global parameter, store/restore, homing and axis-read frames
//
// Overview of operation
// (RL1) code 9 writes parameter, banks 0/2/3
// (RL2) bank 0 module, 2 user, 3 interrupt
// (RL3) bank 0 writes also commit to nv
// (RL4) code 10 reads parameter, value ignored
// (RL5) direct-mode read replies 100 with value
// (RL6) code 11 bank 2 stores user variable
// (RL7) code 12 bank 2 restores user variable
// (RL8) user variables reload from nv after reset
// (RL9) code 13: start, stop, query homing
// (RL10) homing query: zero idle, nonzero running
// (RL11) frame: addr, instr, type, bank, value, sum
// (RL12) bank 0 parameter 66 is bus address
// (RL13) code 6 reads axis parameter; 1 position
// (RL14) accumulator only updated in standalone mode
// (RL15) reply: host, addr, status, instr, value, sum
// (RL16) checksum is byte sum, checked first
`timescale 1ns/100ps
module ghc_decoder (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// command byte stream
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	output logic RX_READY,
	// reply byte stream
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY,
	// non-volatile store
	output ghc_pkg::ghc_nv_req_t NV_REQ,
	input wire ghc_pkg::ghc_nv_rsp_t NV_RSP,
	// motion side
	output ghc_pkg::ghc_home_t HOME_CMD,
	input wire logic [ghc_pkg::NUM_MOTORS-1:0] HOME_BUSY,
	input wire logic [ghc_pkg::NUM_MOTORS-1:0][31:0] ACT_POS,
	// mode pin and accumulator
	input wire logic STANDALONE,
	output logic [31:0] ACCU
);
	import ghc_pkg::*;

	// all decoder state in one word
	typedef struct packed {
		ghc_state_t fsm;
		logic [8:0][7:0] frame; // received bytes, index = position
		logic [3:0] cnt; // receive or reply byte index
		logic [7:0] sum; // running checksum
		logic sum_ok; // received sum matched
		logic [7:0] dev_addr; // address we answer to
		logic [7:0] status; // reply status
		logic [31:0] value; // reply value
		logic [31:0] accu; // accumulator
		ghc_nv_req_t nv; // nv request, held until ack
		ghc_home_t home; // one-cycle homing strobes
		logic [1:0] sync; // standalone pin synchroniser
		logic rx_ready;
	} ghc_st_t;

	ghc_st_t q, d;

	// parameter storage: slot 0 module, 1 user, 2 interrupt banks
	logic [31:0] mem [0:2][0:255];
	logic mem_we;
	logic [1:0] mem_slot;
	logic [7:0] mem_idx;
	logic [31:0] mem_wdata;

	// frame fields
	logic [7:0] f_addr;
	logic [7:0] f_instr;
	logic [7:0] f_type;
	logic [7:0] f_bank;
	logic [31:0] f_value;
	logic [31:0] rd_data;
	logic [7:0] tx_byte;
	logic fifo_in_valid;
	logic fifo_in_ready;

	// bank byte to storage slot; also used on reads, writes and restore
	function automatic logic [1:0] bank_slot(input logic [7:0] bank);
		case (bank)
			BANK_MODULE: bank_slot = 2'h0;
			BANK_USER: bank_slot = 2'h1;
			default: bank_slot = 2'h2;
		endcase
	endfunction : bank_slot

	// only the three documented banks are accepted
	function automatic logic bank_valid(input logic [7:0] bank);
		bank_valid = (bank == BANK_MODULE) || (bank == BANK_USER) || (bank == BANK_IRQ); // [RL2]
	endfunction : bank_valid

	assign f_addr = q.frame[POS_ADDR];
	assign f_instr = q.frame[POS_INSTR];
	assign f_type = q.frame[POS_TYPE];
	assign f_bank = q.frame[POS_BANK];
	assign f_value = {q.frame[POS_VAL3], q.frame[POS_VAL2], q.frame[POS_VAL1], q.frame[POS_VAL0]}; // [RL11]

	// parameter read port; the bus address lives in its own register
	always_comb
	begin
		if (f_bank == BANK_MODULE && f_type == PARAM_BUS_ADDR)
			rd_data = {24'h000000, q.dev_addr}; // [RL12]
		else
			rd_data = mem[bank_slot(f_bank)][f_type];
	end

	// reply byte for the current index, most significant value byte first
	always_comb
	begin
		case (q.cnt)
			4'h0: tx_byte = HOST_ADDR; // [RL15]
			4'h1: tx_byte = q.dev_addr;
			4'h2: tx_byte = q.status;
			4'h3: tx_byte = f_instr;
			4'h4: tx_byte = q.value[31:24];
			4'h5: tx_byte = q.value[23:16];
			4'h6: tx_byte = q.value[15:8];
			4'h7: tx_byte = q.value[7:0];
			default: tx_byte = q.sum;
		endcase
	end

	// next-state logic
	always_comb
	begin
		d = q;
		d.home = '0;
		d.sync = {q.sync[0], STANDALONE};
		mem_we = 1'b0;
		mem_slot = 2'h0;
		mem_idx = 8'h00;
		mem_wdata = 32'h00000000;
		fifo_in_valid = 1'b0;
		case (q.fsm)
			// walk every user variable back out of nv after reset
			S_BOOT:
			begin
				d.nv.req = 1'b1; // one word per request: dropped at each ack, raised again a cycle later
				if (NV_RSP.ack)
				begin
					d.nv.req = 1'b0;
					mem_we = 1'b1; // [RL8]
					mem_slot = bank_slot(BANK_USER);
					mem_idx = q.nv.idx;
					mem_wdata = NV_RSP.rdata;
					if (q.nv.idx == PARAM_LAST)
					begin
						d.fsm = S_RECV;
						d.rx_ready = 1'b1;
					end
					else
						d.nv.idx = q.nv.idx + 8'h01;
				end
			end
			// gather nine bytes, summing the first eight
			S_RECV:
			begin
				if (RX_VALID)
				begin
					d.frame[q.cnt] = RX_DATA; // [RL11]
					if (q.cnt == FRAME_LAST)
					begin
						d.sum_ok = (q.sum == RX_DATA); // [RL16]
						d.sum = 8'h00;
						d.cnt = 4'h0;
						d.rx_ready = 1'b0;
						d.fsm = S_EXEC;
					end
					else
					begin
						d.sum = q.sum + RX_DATA; // [RL16]
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			// decode the captured frame
			S_EXEC:
			begin
				d.status = ST_OK;
				d.value = 32'h00000000;
				d.fsm = S_REPLY;
				if (f_addr != q.dev_addr)
				begin
					// frames for other nodes are dropped without a reply
					d.fsm = S_RECV;
					d.rx_ready = 1'b1;
				end
				else if (!q.sum_ok)
					d.status = ST_BAD_SUM; // [RL16]
				else
				begin
					case (f_instr)
						CMD_SET_GLOBAL:
						begin
							if (!bank_valid(f_bank))
								d.status = ST_BAD_VALUE;
							else
							begin
								mem_we = 1'b1; // [RL1]
								mem_slot = bank_slot(f_bank);
								mem_idx = f_type;
								mem_wdata = f_value;
								if (f_bank == BANK_MODULE && f_type == PARAM_BUS_ADDR)
									d.dev_addr = f_value[7:0]; // [RL12]
								if (f_bank == BANK_MODULE)
								begin
									// module settings persist with no separate store
									d.nv = '{req: 1'b1, we: 1'b1, bank: f_bank, idx: f_type, wdata: f_value}; // [RL3]
									d.fsm = S_NVWAIT;
								end
							end
						end
						CMD_GET_GLOBAL:
						begin
							if (!bank_valid(f_bank))
								d.status = ST_BAD_VALUE;
							else
							begin
								d.value = rd_data; // [RL4] [RL5]
								if (q.sync[1])
									d.accu = rd_data; // [RL14]
							end
						end
						CMD_STORE_GLOBAL:
						begin
							if (f_bank != BANK_USER)
								d.status = ST_BAD_VALUE;
							else
							begin
								d.nv = '{req: 1'b1, we: 1'b1, bank: f_bank, idx: f_type, wdata: rd_data}; // [RL6]
								d.fsm = S_NVWAIT;
							end
						end
						CMD_RESTORE_GLOBAL:
						begin
							if (f_bank != BANK_USER)
								d.status = ST_BAD_VALUE;
							else
							begin
								d.nv = '{req: 1'b1, we: 1'b0, bank: f_bank, idx: f_type, wdata: 32'h00000000}; // [RL7]
								d.fsm = S_NVWAIT;
							end
						end
						CMD_HOMING:
						begin
							if (f_bank > MOTOR_LAST)
								d.status = ST_BAD_VALUE;
							else if (f_type == HOME_START)
								d.home.start[f_bank[1:0]] = 1'b1; // [RL9]
							else if (f_type == HOME_STOP)
								d.home.stop[f_bank[1:0]] = 1'b1; // [RL9]
							else if (f_type == HOME_STATUS)
								d.value = {31'h00000000, HOME_BUSY[f_bank[1:0]]}; // [RL10]
							else
								d.status = ST_BAD_TYPE;
						end
						CMD_GET_AXIS:
						begin
							if (f_bank > MOTOR_LAST)
								d.status = ST_BAD_VALUE;
							else if (f_type == AXIS_ACT_POS)
							begin
								d.value = ACT_POS[f_bank[1:0]]; // [RL13]
								if (q.sync[1])
									d.accu = ACT_POS[f_bank[1:0]]; // [RL14]
							end
							else
								d.status = ST_BAD_TYPE;
						end
						default:
							d.status = ST_BAD_CMD;
					endcase
				end
			end
			// hold the nv request until the store answers
			S_NVWAIT:
			begin
				if (NV_RSP.ack)
				begin
					d.nv.req = 1'b0;
					d.fsm = S_REPLY;
					if (!q.nv.we)
					begin
						mem_we = 1'b1; // [RL7]
						mem_slot = bank_slot(q.nv.bank);
						mem_idx = q.nv.idx;
						mem_wdata = NV_RSP.rdata;
					end
				end
			end
			// push the reply; a full fifo simply stalls this state
			S_REPLY:
			begin
				fifo_in_valid = 1'b1;
				if (fifo_in_ready)
				begin
					if (q.cnt == FRAME_LAST)
					begin
						d.cnt = 4'h0;
						d.sum = 8'h00;
						d.fsm = S_RECV;
						d.rx_ready = 1'b1;
					end
					else
					begin
						d.sum = q.sum + tx_byte; // [RL15]
						d.cnt = q.cnt + 4'h1;
					end
				end
			end
			default:
			begin
				d.fsm = S_RECV;
				d.rx_ready = 1'b1;
			end
		endcase
	end

	// state register; reset starts the user-variable reload at index 0
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			q <= '0;
			q.fsm <= S_BOOT;
			q.dev_addr <= ADDR_RESET;
			q.nv.req <= 1'b1; // [RL8]
			q.nv.bank <= BANK_USER;
		end
		else
			q <= d;
	end

	// parameter storage has no reset; contents come from nv or writes
	always_ff @(posedge CORE_CLK)
	begin
		if (mem_we)
			mem[mem_slot][mem_idx] <= mem_wdata;
	end

	// reply buffer; the drain can stall so the sequencer waits on it
	ghc_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(CORE_CLK),
		.arst_n(ARST_N),
		.in_valid(fifo_in_valid),
		.in_data(tx_byte),
		.in_ready(fifo_in_ready),
		.out_valid(TX_VALID),
		.out_data(TX_DATA),
		.out_ready(TX_READY)
	);

	assign RX_READY = q.rx_ready;
	assign NV_REQ = q.nv;
	assign HOME_CMD = q.home;
	assign ACCU = q.accu;

endmodule : ghc_decoder

// ==== src/ghc_decoder_note_unused.sv ====
// spare source slot; holds no logic

// ==== verif/ghc_decoder_monitor.sv ====
// checker bound to the decoder ports
`timescale 1ns/100ps
module ghc_decoder_monitor (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// byte streams
	input wire logic RX_VALID,
	input wire logic RX_READY,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_READY,
	// store, motion and mode
	input wire ghc_pkg::ghc_nv_req_t NV_REQ,
	input wire ghc_pkg::ghc_nv_rsp_t NV_RSP,
	input wire ghc_pkg::ghc_home_t HOME_CMD,
	input wire logic STANDALONE,
	input wire logic [31:0] ACCU
);
	import ghc_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// bytes taken so far in this frame
	logic [3:0] cnt_q;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
		if (!ARST_N)
			cnt_q <= 4'h0;
		else if (RX_VALID && RX_READY)
			cnt_q <= (cnt_q == FRAME_LAST) ? 4'h0 : cnt_q + 4'h1;
	AST_RX_STOP: assert property (RX_VALID && RX_READY && cnt_q == FRAME_LAST |=> !RX_READY)
		else $error("receive still open after ninth byte");
	AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte changed before taken");
	AST_TX_QUIET: assert property ($rose(TX_VALID) |-> !RX_READY)
		else $error("reply starts while receiving");
	AST_NV_HOLD: assert property (NV_REQ.req && !NV_RSP.ack |=> NV_REQ.req && $stable(NV_REQ))
		else $error("store request moved before ack");
	AST_NV_DROP: assert property (NV_REQ.req && NV_RSP.ack |=> !NV_REQ.req)
		else $error("store request kept after ack");
	AST_HOME_ONE: assert property (|HOME_CMD |-> $onehot(HOME_CMD))
		else $error("several homing strobes at once");
	AST_HOME_PULSE: assert property (|HOME_CMD |=> !(|HOME_CMD) [*2])
		else $error("homing strobe longer than a cycle");
	AST_ACCU_KEEP: assert property (!STANDALONE && !$past(STANDALONE) && !$past(STANDALONE, 2)
		&& !$past(STANDALONE, 3) |-> $stable(ACCU)) else $error("accumulator moved in direct mode");
endmodule : ghc_decoder_monitor
bind ghc_decoder ghc_decoder_monitor mon_u (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .RX_VALID(RX_VALID),
	.RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .NV_REQ(NV_REQ),
	.NV_RSP(NV_RSP), .HOME_CMD(HOME_CMD), .STANDALONE(STANDALONE), .ACCU(ACCU));

// ==== verif/ghc_host_model.sv ====
// host side model: sends command frames, collects replies
`timescale 1ns/100ps
module ghc_host_model (
	// clock
	input wire logic clk,
	// command stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	// reply stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	// idle at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// whole frame back to back once receive is open; enter at a clock edge
	task automatic send_frame(input logic [0:8][7:0] f);
		int w;
		w = 0;
		#1;
		while (!rx_ready && w < 4000)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		@(posedge clk);
		for (int i = 0; i < 9; i++)
		begin
			rx_valid <= 1'b1;
			rx_data <= f[i];
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		// released data line must not look valid
		rx_data <= ~f[8];
	endtask : send_frame
	// stall lets the reply fifo fill before draining
	task automatic recv_reply(input int stall, output logic [0:8][7:0] r, output int n);
		int w;
		n = 0;
		w = 0;
		r = '1;
		repeat (stall) @(posedge clk);
		tx_ready <= 1'b1;
		while (n < 9 && w < 400)
		begin
			#1;
			if (tx_valid)
			begin
				r[n] = tx_data;
				n++;
			end
			@(posedge clk);
			w++;
		end
		tx_ready <= 1'b0;
	endtask : recv_reply
endmodule : ghc_host_model

// ==== verif/ghc_decoder_tb.sv ====
// self-checking bench for the command decoder
`timescale 1ns/100ps
module ghc_decoder_tb;
	import ghc_pkg::*;
	// decoder pins
	logic clk, arst_n, standalone, rx_valid, rx_ready, tx_valid, tx_ready, nv_ack;
	logic [NUM_MOTORS-1:0] home_busy;
	logic [NUM_MOTORS-1:0][31:0] act_pos;
	logic [7:0] rx_data, tx_data, dev_addr;
	logic [31:0] accu, nv_rdata;
	ghc_nv_req_t nv_req;
	ghc_nv_rsp_t nv_rsp;
	ghc_home_t home_cmd, last_home;
	// store model state
	logic [1:0] nv_cnt;
	logic [47:0] nv_last;
	logic [31:0] nv_mem [0:255];
	int err_total, check_count;
	assign nv_rsp = {nv_ack, nv_rdata};
	ghc_decoder dut_u (.CORE_CLK(clk), .ARST_N(arst_n), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .NV_REQ(nv_req),
		.NV_RSP(nv_rsp), .HOME_CMD(home_cmd), .HOME_BUSY(home_busy), .ACT_POS(act_pos),
		.STANDALONE(standalone), .ACCU(accu));
	ghc_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// slow store: ack three edges into a request, data line churns otherwise
	always @(posedge clk)
	begin
		nv_ack <= 1'b0;
		nv_rdata <= ~nv_rdata;
		if (arst_n && nv_req.req && !nv_ack)
			nv_cnt <= nv_cnt + 2'd1;
		if (arst_n && nv_req.req && !nv_ack && nv_cnt == 2'd2)
		begin
			nv_cnt <= 2'd0;
			nv_ack <= 1'b1;
			nv_rdata <= nv_mem[nv_req.idx];
			if (nv_req.we)
				nv_last <= {nv_req.bank, nv_req.idx, nv_req.wdata};
			if (nv_req.we && nv_req.bank == BANK_USER)
				nv_mem[nv_req.idx] <= nv_req.wdata;
		end
	end
	// latch the last homing strobe
	always @(posedge clk)
		if (|home_cmd)
			last_home <= home_cmd;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one command and its whole reply; a set of the bus address moves dev_addr
	task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input logic [7:0] st,
		input logic [31:0] ev, input int stall, input logic [7:0] skew);
		logic [0:8][7:0] f, r;
		logic [7:0] s, ra;
		int n;
		ra = (ins == CMD_SET_GLOBAL && typ == PARAM_BUS_ADDR && bnk == BANK_MODULE && st == ST_OK) ? val[7:0] : dev_addr;
		f = {dev_addr, ins, typ, bnk, val, 8'h00};
		s = 8'h00;
		for (int i = 0; i < 8; i++) s += f[i];
		f[8] = s + skew;
		host_u.send_frame(f);
		host_u.recv_reply(stall, r, n);
		dev_addr = ra;
		s = 8'h00;
		for (int i = 0; i < 8; i++) s += r[i];
		chk("reply bytes", 32'(n), 32'd9);
		chk("host addr", 32'(r[0]), 32'(HOST_ADDR));
		chk("dev addr", 32'(r[1]), 32'(ra));
		chk("status", 32'(r[2]), 32'(st));
		chk("echo", 32'(r[3]), 32'(ins));
		if (st == ST_OK) chk("value", r[4:7], ev);
		chk("reply sum", 32'(r[8]), 32'(s));
	endtask : cmd
	task automatic t_boot();
		cmd(CMD_GET_GLOBAL, 8'h05, BANK_USER, 32'hdeadbeef, ST_OK, 32'h5a000005, 12, 0);
		chk("accu direct", accu, 32'h0);
	endtask : t_boot
	task automatic t_set_get();
		for (int b = 2; b < 4; b++)
		begin
			cmd(CMD_SET_GLOBAL, 8'h07, 8'(b), 32'h12345678 + b, ST_OK, 0, 0, 0);
			cmd(CMD_GET_GLOBAL, 8'h07, 8'(b), 0, ST_OK, 32'h12345678 + b, 0, 0);
		end
		cmd(CMD_SET_GLOBAL, 8'h07, 8'h01, 0, ST_BAD_VALUE, 0, 0, 0);
	endtask : t_set_get
	task automatic t_addr();
		logic seen;
		seen = 1'b0;
		cmd(CMD_SET_GLOBAL, PARAM_BUS_ADDR, BANK_MODULE, 32'h3, ST_OK, 0, 0, 0);
		chk("auto commit", nv_last[47:16], {BANK_MODULE, PARAM_BUS_ADDR, 16'h0});
		chk("commit data", 32'(nv_last[15:0]), 32'h3);
		host_u.send_frame({8'h01, CMD_GET_GLOBAL, PARAM_BUS_ADDR, BANK_MODULE, 32'h0, 8'h4d});
		repeat (30)
		begin
			#1;
			seen |= tx_valid;
			@(posedge clk);
		end
		#1;
		chk("foreign frame reply", 32'(seen), 0);
		chk("receive reopened", 32'(rx_ready), 1);
		@(posedge clk);
		cmd(CMD_GET_GLOBAL, PARAM_BUS_ADDR, BANK_MODULE, 0, ST_OK, 32'h3, 0, 0);
	endtask : t_addr
	task automatic t_store();
		cmd(CMD_SET_GLOBAL, 8'h09, BANK_USER, 32'h0badcafe, ST_OK, 0, 0, 0);
		cmd(CMD_STORE_GLOBAL, 8'h09, BANK_USER, 0, ST_OK, 0, 0, 0);
		chk("stored word", nv_mem[9], 32'h0badcafe);
		cmd(CMD_STORE_GLOBAL, 8'h09, BANK_MODULE, 0, ST_BAD_VALUE, 0, 0, 0);
		cmd(CMD_SET_GLOBAL, 8'h09, BANK_USER, 32'h11111111, ST_OK, 0, 0, 0);
		cmd(CMD_RESTORE_GLOBAL, 8'h09, BANK_USER, 0, ST_OK, 0, 0, 0);
		cmd(CMD_GET_GLOBAL, 8'h09, BANK_USER, 0, ST_OK, 32'h0badcafe, 0, 0);
	endtask : t_store
	task automatic t_home();
		for (int m = 0; m < NUM_MOTORS; m++)
		begin
			home_busy <= 3'(1 << m);
			cmd(CMD_HOMING, HOME_START, 8'(m), 0, ST_OK, 0, 0, 0);
			chk("start strobe", 32'(last_home), 32'h8 << m);
			cmd(CMD_HOMING, HOME_STATUS, 8'(m), 0, ST_OK, 32'h1, 0, 0);
			home_busy <= '0;
			cmd(CMD_HOMING, HOME_STATUS, 8'(m), 0, ST_OK, 0, 0, 0);
			cmd(CMD_HOMING, HOME_STOP, 8'(m), 0, ST_OK, 0, 0, 0);
			chk("stop strobe", 32'(last_home), 32'h1 << m);
		end
		cmd(CMD_HOMING, HOME_START, 8'h03, 0, ST_BAD_VALUE, 0, 0, 0);
	endtask : t_home
	task automatic t_axis();
		standalone <= 1'b1;
		cmd(CMD_GET_AXIS, AXIS_ACT_POS, 8'h01, 0, ST_OK, act_pos[1], 0, 0);
		chk("accu axis", accu, act_pos[1]);
		cmd(CMD_GET_GLOBAL, 8'h05, BANK_USER, 0, ST_OK, 32'h5a000005, 0, 0);
		chk("accu global", accu, 32'h5a000005);
		cmd(CMD_GET_AXIS, 8'h02, 8'h01, 0, ST_BAD_TYPE, 0, 0, 0);
		standalone <= 1'b0;
	endtask : t_axis
	task automatic t_bad_sum();
		cmd(CMD_SET_GLOBAL, 8'h09, BANK_USER, 32'h2222, ST_BAD_SUM, 0, 0, 8'h01);
		cmd(CMD_GET_GLOBAL, 8'h09, BANK_USER, 0, ST_OK, 32'h0badcafe, 0, 0);
		chk("accu kept", accu, 32'h5a000005);
		cmd(8'h05, 8'h00, 8'h00, 0, ST_BAD_CMD, 0, 0, 0);
		cmd(CMD_HOMING, 8'h03, 8'h00, 0, ST_BAD_TYPE, 0, 0, 0);
		cmd(CMD_GET_GLOBAL, 8'h09, 8'h01, 0, ST_BAD_VALUE, 0, 0, 0);
		cmd(CMD_RESTORE_GLOBAL, 8'h09, BANK_IRQ, 0, ST_BAD_VALUE, 0, 0, 0);
		cmd(CMD_GET_AXIS, AXIS_ACT_POS, 8'h03, 0, ST_BAD_VALUE, 0, 0, 0);
	endtask : t_bad_sum
	task automatic test_done();
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// hang guard: boot plus all frames fit well inside 60000 cycles
	initial
	begin
		#2400000;
		err_total++;
		test_done();
	end
	initial
	begin
		arst_n = 1'b0;
		standalone = 1'b0;
		home_busy = '0;
		err_total = 0;
		check_count = 0;
		dev_addr = ADDR_RESET;
		nv_ack = 1'b0;
		nv_rdata = 32'h0;
		nv_cnt = 2'd0;
		nv_last = '0;
		last_home = '0;
		for (int m = 0; m < NUM_MOTORS; m++) act_pos[m] = 32'h00100077 + m;
		for (int i = 0; i < 256; i++) nv_mem[i] = 32'h5a000000 + i;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_boot();
		t_set_get();
		t_addr();
		t_store();
		t_home();
		t_axis();
		t_bad_sum();
		test_done();
	end
endmodule : ghc_decoder_tb
